// file: rtl/sadc_core.sv
/*
 * Conversion sequencer and serial result shifter of a 16-bit sampling converter.
 * Assumes the host drives convert start, chip select, frame sync and the serial
 * clock asynchronously to clock_i; the serial clock is sampled, not used as a clock.
 */
`timescale 1ns/1ps

module sadc_core
   import sadc_pkg::*;
(
   input  wire logic              clock_i,            // System clock, 40 MHz.
   input  wire logic              srst_i,             // Synchronous reset, active high.
   input  wire logic              convert_start_n_i,  // Convert start pin, active low.
   input  wire logic              chip_select_n_i,    // Chip select pin, active low.
   input  wire logic              frame_sync_in_i,    // Frame sync pin.
   input  wire logic              serial_clock_i,     // Serial read clock pin.
   input  wire logic [DATA_W-1:0] sample_code_i,      // Two's complement code from the array.
   output logic                   busy_o,             // High while converting.
   output logic                   nap_o,              // High while in the nap state.
   output logic                   serial_data_o,      // Serial data out.
   output logic                   serial_data_oe_n_o  // Low while serial data is driven.
);

   // Three-stage synchronisers; stages two and three are compared for a change.
   logic [2:0] cs_sync;
   logic [2:0] cv_sync;
   logic [2:0] fs_sync;
   logic [2:0] sk_sync;
   logic       cs_n;
   logic       cv_n;
   logic       fs;
   logic       sk;

   // All pin inputs enter through the same synchroniser chain.
   // Every stage resets to the idle level of its pin, so no false edge follows reset.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cs_sync <= 3'h7;
         cv_sync <= 3'h7;
         fs_sync <= 3'h7;
         sk_sync <= 3'h7;
      end else begin
         cs_sync <= {cs_sync[1:0], chip_select_n_i};
         cv_sync <= {cv_sync[1:0], convert_start_n_i};
         fs_sync <= {fs_sync[1:0], frame_sync_in_i};
         sk_sync <= {sk_sync[1:0], serial_clock_i};
      end
   end

   // A level changes only once stages two and three agree.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cs_n <= 1'b1;
         cv_n <= 1'b1;
         fs   <= 1'b1;
         sk   <= 1'b1;
      end else begin
         if (cs_sync[1] == cs_sync[2]) cs_n <= cs_sync[2];
         if (cv_sync[1] == cv_sync[2]) cv_n <= cv_sync[2];
         if (fs_sync[1] == fs_sync[2]) fs <= fs_sync[2];
         if (sk_sync[1] == sk_sync[2]) sk <= sk_sync[2];
      end
   end

   logic cs_q;
   logic fs_q;
   logic sk_q;
   logic qual_n;
   logic qual_q;

   // Qualified convert start follows convert start only while selected.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         qual_n <= 1'b1;
         qual_q <= 1'b1;
         cs_q   <= 1'b1;
         fs_q   <= 1'b1;
         sk_q   <= 1'b1;
      end else begin
         if (!cs_n) qual_n <= cv_n;
         qual_q <= qual_n;
         cs_q   <= cs_n;
         fs_q   <= fs;
         sk_q   <= sk;
      end
   end

   logic qual_fall;
   logic sample_cmd;
   // The qualifier only moves while selected, so a convert-start edge made with
   // the select high is held off until the next select.
   assign qual_fall  = qual_q && !qual_n;
   // Sample start command is convert start high seen with chip select low.
   assign sample_cmd = !cs_n && cv_n;

   sadc_state_e      state;
   logic [CNT_W-1:0] conv_cnt;
   logic             conv_end;
   logic [DATA_W-1:0] result;
   logic             busy_fall;
   logic             busy_q;
   assign conv_end = (state == SADC_CONVERT) && (conv_cnt == CONV_LAST);

   // Converter sequencer.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state <= SADC_WAIT;
      end else begin
         case (state)
            SADC_SAMPLE: begin
               if (qual_fall) state <= SADC_CONVERT;
            end
            SADC_CONVERT: begin
               if (qual_fall) begin
                  state <= SADC_WAIT;
               end else if (conv_end && sample_cmd) begin
                  state <= SADC_SAMPLE;
               end else if (conv_end) begin
                  state <= qual_n ? SADC_WAIT : SADC_NAP;
               end
            end
            SADC_WAIT, SADC_NAP: begin
               if (sample_cmd) state <= SADC_SAMPLE;
            end
            default: state <= SADC_WAIT;
         endcase
      end
   end

   // Internal conversion timer; the count only runs while converting.
   always_ff @(posedge clock_i) begin
      if (srst_i || state != SADC_CONVERT) conv_cnt <= CNT_ZERO;
      else if (!conv_end) conv_cnt <= conv_cnt + 7'h01;
   end

   // Result store; a completed code replaces it at the busy fall.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         result <= RESULT_RESET;
      end else if (state == SADC_CONVERT && qual_fall) begin
         result <= ABORT_PATTERN;
      end else if (conv_end) begin
         result <= sample_code_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         busy_o <= 1'b0;
         nap_o  <= 1'b0;
      end else begin
         busy_o <= (state == SADC_CONVERT) && !conv_end && !qual_fall;
         nap_o  <= (state == SADC_NAP);
      end
   end

   // Busy delayed by one cycle; its fall is seen only after the result has
   // been replaced, so a reload never picks up the stale code.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= busy_o;
      end
   end
   assign busy_fall = busy_q && !busy_o;

   logic [DATA_W-1:0] shreg;
   logic              armed;
   logic              fs_mode;
   logic              cs_fall;
   logic              fs_rise;
   logic              fs_fall;
   logic              sk_rise;
   logic              sk_fall;
   assign cs_fall = cs_q && !cs_n;
   assign fs_rise = !fs_q && fs && !cs_n;
   assign fs_fall = fs_q && !fs && !cs_n;
   assign sk_rise = !sk_q && sk;
   assign sk_fall = sk_q && !sk;

   // Readout shifter: data is loaded from the held result, so a read during a
   // conversion gives the previous sample. The result is read one cycle after
   // its update, which keeps the busy-fall reload aligned with the new code.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         shreg   <= RESULT_RESET;
         armed   <= 1'b0;
         fs_mode <= 1'b0;
      end else if (cs_fall) begin
         shreg   <= result;
         armed   <= 1'b0;
         fs_mode <= !fs;
      end else if (fs_rise) begin
         shreg   <= result;
         armed   <= 1'b0;
         fs_mode <= 1'b1;
      end else if (busy_fall && fs && fs_mode && !cs_n) begin
         shreg <= result;
         armed <= 1'b0;
      end else if (!cs_n) begin
         // Arm on the first clock fall, after sync fall in sync mode.
         if (sk_fall && (!fs_mode || !fs)) armed <= 1'b1;
         if (sk_rise && armed) shreg <= {shreg[DATA_W-2:0], 1'b0};
      end
   end

   // Output stage; the pin floats whenever chip select is high.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         serial_data_o      <= 1'b0;
         serial_data_oe_n_o <= 1'b1;
      end else begin
         serial_data_o      <= shreg[MSB_IDX];
         serial_data_oe_n_o <= cs_n;
      end
   end

   // Checks on the sequencer and the shifter. They watch internal state, so a
   // failure points at the step that went wrong rather than at the pins.
   // Pin-level timing is left to the bench, which sees the synchroniser delay.
   sequence conv_start_s;
      state == SADC_SAMPLE && qual_fall;
   endsequence

   // A reload is due when busy falls while a sync-framed read is held open.
   sequence sync_reload_s;
      busy_fall && fs && fs_mode && !cs_n;
   endsequence

   conv_start_a: assert property (@(posedge clock_i) disable iff (srst_i)
      conv_start_s |=> state == SADC_CONVERT ##1 busy_o)
      else $error("Conversion did not start on qualified fall.");
   sample_start_a: assert property (@(posedge clock_i) disable iff (srst_i)
      (state == SADC_WAIT || state == SADC_NAP) && sample_cmd |=> state == SADC_SAMPLE)
      else $error("Sampling did not start from idle.");
   back_to_back_a: assert property (@(posedge clock_i) disable iff (srst_i)
      conv_end && sample_cmd && !qual_fall |=> state == SADC_SAMPLE)
      else $error("Back-to-back sampling missed.");
   nap_entry_a: assert property (@(posedge clock_i) disable iff (srst_i)
      conv_end && !sample_cmd && !qual_fall && !qual_n |=> state == SADC_NAP)
      else $error("Nap not entered with low qualifier.");
   wait_entry_a: assert property (@(posedge clock_i) disable iff (srst_i)
      conv_end && !sample_cmd && !qual_fall && qual_n |=> state == SADC_WAIT)
      else $error("Wait not entered.");
   abort_wait_a: assert property (@(posedge clock_i) disable iff (srst_i)
      state == SADC_CONVERT && qual_fall |=> state == SADC_WAIT && !busy_o)
      else $error("Abort did not reach wait.");
   abort_code_a: assert property (@(posedge clock_i) disable iff (srst_i)
      state == SADC_CONVERT && qual_fall |=> result == ABORT_PATTERN)
      else $error("Abort pattern not stored.");
   busy_length_a: assert property (@(posedge clock_i) disable iff (srst_i)
      busy_o && !qual_fall && conv_cnt < CONV_LAST |=> busy_o)
      else $error("Busy dropped before the conversion ended.");
   conv_time_a: assert property (@(posedge clock_i) disable iff (srst_i)
      state == SADC_CONVERT |-> conv_cnt <= CONV_LAST)
      else $error("Conversion timer overran.");
   msb_load_a: assert property (@(posedge clock_i) disable iff (srst_i)
      cs_fall |=> shreg == $past(result) ##1 serial_data_o == $past(result[MSB_IDX], 2))
      else $error("MSB not presented at select fall.");
   reload_msb_a: assert property (@(posedge clock_i) disable iff (srst_i)
      sync_reload_s |=> shreg == $past(result))
      else $error("Shifter not reloaded at busy fall.");
endmodule

// file: rtl/sadc_pkg.sv
/*
 * Constants for the converter sequencing and serial readout block.
 * Assumes a single 40 MHz system clock and no software-reachable registers.
 */
package sadc_pkg;
   localparam int          CLK_PERIOD_PS  = 25000;  // System clock period in picoseconds.
   localparam int          CONV_TIME_PS   = 1100000; // Longest conversion time, 1.1 us.
   // Longest time rounds down to whole cycles.
   localparam int          CONV_CYCLES    = CONV_TIME_PS / CLK_PERIOD_PS;
   localparam int          CNT_W          = 7;
   localparam logic [6:0]  CONV_LAST      = 7'(CONV_CYCLES - 1);
   localparam logic [6:0]  CNT_ZERO       = 7'h00;
   localparam int          DATA_W         = 16;
   localparam logic [15:0] ABORT_PATTERN  = 16'hFF00;
   localparam logic [15:0] RESULT_RESET   = 16'h0000;
   localparam int          MSB_IDX        = 15;
   localparam logic [1:0]  SYNC_RESET     = 2'h3;

   // Gray-coded converter states in the order sample, convert, wait, nap.
   typedef enum logic [1:0] {
      SADC_SAMPLE  = 2'b00,
      SADC_CONVERT = 2'b01,
      SADC_WAIT    = 2'b11,
      SADC_NAP     = 2'b10
   } sadc_state_e;
endpackage

// file: testbench/sadc_host.sv
/* Host controller model: drives convert start, select, frame sync and the serial clock.
   Assumes the bench clock paces it and the serial line is resolved outside. */
`timescale 1ns/1ps
module sadc_host (
   input  wire logic clock_i,           // Pacing clock.
   input  wire logic sdo_i,             // Resolved serial data line.
   output logic      convert_start_n_o, // Convert start, active low.
   output logic      chip_select_n_o,   // Chip select, active low.
   output logic      frame_sync_in_o,   // Frame sync.
   output logic      serial_clock_o     // Serial clock, idles high.
);
   // sync held high
   // All pins idle high; frame sync stays high except in sync-framed reads.
   initial begin
      {convert_start_n_o, chip_select_n_o, frame_sync_in_o, serial_clock_o} = 4'hF;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic pins(input logic cv, input logic cs, input logic fs);
      @(negedge clock_i);
      {convert_start_n_o, chip_select_n_o, frame_sync_in_o} = {cv, cs, fs};
   endtask
   // quiet clocked read
   // The clock runs only inside a frame, so convert-start edges see a quiet bus.
   // Bits are taken just before each rise, when the previous shift has settled.
   task automatic frame(input bit fsm, input int n, output logic [15:0] d);
      d = 16'h0000;
      if (fsm) begin
         pins(convert_start_n_o, 1'b0, 1'b0);
         idle(8);
         pins(convert_start_n_o, 1'b0, 1'b1);
         idle(12);
         pins(convert_start_n_o, 1'b0, 1'b0);
      end else begin
         pins(convert_start_n_o, 1'b1, 1'b1);
         idle(8);
         pins(convert_start_n_o, 1'b0, 1'b1);
      end
      idle(12);
      shift(n, d);
   endtask
   // Clocks n bits out of a frame that is already open.
   task automatic shift(input int n, output logic [15:0] d);
      d = 16'h0000;
      serial_clock_o = 1'b0;
      idle(4);
      for (int i = 0; i < n; i++) begin
         d = {d[14:0], sdo_i};
         serial_clock_o = 1'b1;
         idle(4);
         serial_clock_o = 1'b0;
         idle(4);
      end
      serial_clock_o = 1'b1;
   endtask
endmodule

// file: testbench/tb_sar_adc_convert_and_serial_read.sv
/* Self-checking bench for the converter sequencer and serial readout.
   Assumes sadc_core and the sadc_host partner model are compiled first. */
`timescale 1ns/1ps
module tb_sar_adc_convert_and_serial_read;
   import sadc_pkg::*;
   logic              clock_i = 1'b0;
   logic              srst_i  = 1'b1;
   logic [DATA_W-1:0] code    = RESULT_RESET;
   wire               busy, nap, sdo, sdo_oe_n, cv_n, cs_n, fs, sclk;
   logic [15:0]       rd;
   int                cnt;
   int                err_total = 0;
   int                n_tests   = 0;
   // A released data line is pulled high, so stale bits cannot pass.
   wire               sdo_w = sdo_oe_n ? 1'b1 : sdo;

   // The clock toggles every 12.5 ns, half of its 25 ns period.
   always #12.5 clock_i = ~clock_i;

   sadc_core DUT (.clock_i(clock_i), .srst_i(srst_i), .convert_start_n_i(cv_n),
      .chip_select_n_i(cs_n), .frame_sync_in_i(fs), .serial_clock_i(sclk),
      .sample_code_i(code), .busy_o(busy), .nap_o(nap), .serial_data_o(sdo),
      .serial_data_oe_n_o(sdo_oe_n));
   sadc_host host (.clock_i(clock_i), .sdo_i(sdo_w), .convert_start_n_o(cv_n),
      .chip_select_n_o(cs_n), .frame_sync_in_o(fs), .serial_clock_o(sclk));

   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bounded wait; running out ends the run.
   task automatic wait_busy(input logic v, input int lim);
      int k;
      k = 0;
      while (busy !== v && k < lim) begin
         @(negedge clock_i);
         k++;
      end
      if (busy !== v) begin
         err_total++;
         $display("ERROR busy expected %b seen %b", v, busy);
         results();
      end
   endtask
   task automatic conv_start(input logic [15:0] c);
      host.pins(1'b1, 1'b0, 1'b1);
      host.idle(8);
      code = c;
      host.pins(1'b0, 1'b0, 1'b1);
      wait_busy(1'b1, 12);
   endtask
   task automatic conv_end();
      cnt = 0;
      while (busy === 1'b1 && cnt < 60) begin
         cnt++;
         @(negedge clock_i);
      end
      wait_busy(1'b0, 1);
   endtask
   task automatic t_nap();
      conv_start(16'h7FFF);
      conv_end();
      chk("busy cycles", 16'(CONV_CYCLES - 1), 16'(cnt));
      host.idle(4);
      chk("nap", 16'h0001, {15'h0, nap});
      host.frame(1'b0, 16, rd);
      chk("full scale", 16'h7FFF, rd);
      $display("t_nap done");
   endtask
   task automatic t_b2b();
      conv_start(16'h8000);
      host.idle(10);
      host.pins(1'b1, 1'b0, 1'b1);
      conv_end();
      host.idle(4);
      chk("nap b2b", 16'h0000, {15'h0, nap});
      host.pins(1'b0, 1'b0, 1'b1);
      wait_busy(1'b1, 12);
      conv_end();
      host.frame(1'b0, 16, rd);
      chk("neg scale", 16'h8000, rd);
      $display("t_b2b done");
   endtask
   task automatic t_abort();
      conv_start(16'h1234);
      host.idle(10);
      host.pins(1'b1, 1'b0, 1'b1);
      host.idle(6);
      host.pins(1'b0, 1'b0, 1'b1);
      wait_busy(1'b0, 10);
      host.idle(50);
      chk("busy after abort", 16'h0000, {15'h0, busy | nap});
      host.frame(1'b0, 16, rd);
      chk("abort code", ABORT_PATTERN, rd);
      $display("t_abort done");
   endtask
   // read away from busy fall
   // The read starts right after busy rises, far from its fall.
   task automatic t_latency();
      conv_start(16'hFFFF);
      host.frame(1'b0, 16, rd);
      chk("previous", ABORT_PATTERN, rd);
      host.frame(1'b0, 16, rd);
      chk("new", 16'hFFFF, rd);
      $display("t_latency done");
   endtask
   task automatic t_restart();
      host.frame(1'b0, 4, rd);
      chk("part select", 16'h000F, rd);
      host.frame(1'b0, 16, rd);
      chk("restart select", 16'hFFFF, rd);
      host.frame(1'b1, 4, rd);
      chk("part sync", 16'h000F, rd);
      host.frame(1'b1, 16, rd);
      chk("restart sync", 16'hFFFF, rd);
      $display("t_restart done");
   endtask
   // A sync-framed read opened during a conversion, with sync still high at
   // the busy fall, must hand out the new code instead of the old one.
   task automatic t_reload();
      conv_start(16'h0000);
      host.pins(1'b0, 1'b0, 1'b0);
      host.idle(8);
      host.pins(1'b0, 1'b0, 1'b1);
      conv_end();
      host.idle(4);
      host.pins(1'b0, 1'b0, 1'b0);
      host.idle(12);
      host.shift(16, rd);
      chk("reload sync", 16'h0000, rd);
      $display("t_reload done");
   endtask

   // Reset for 12 cycles, then run every scenario.
   initial begin
      repeat (12) @(negedge clock_i);
      srst_i = 1'b0;
      host.idle(4);
      t_nap();
      t_b2b();
      t_abort();
      t_latency();
      t_restart();
      t_reload();
      results();
   end
endmodule
